//--- core/plldl_pkg.sv
// shared constants and carrier types for the clock divider and loop control
`default_nettype none
package plldl_pkg;
    localparam int unsigned RATIO_W    = 8;   // prescale ratio width, 1..255
    localparam int unsigned GAIN_W     = 11;  // gain field width
    localparam int unsigned COUNT_W    = 6;   // settle count width
    localparam int unsigned OFF_DELAY  = 2;   // slow ticks until real shutdown
    localparam logic [7:0]  RATIO_RST  = 8'h00;  // ratio after reset
    localparam logic [10:0] GAIN_RST   = 11'h000; // gain after reset
    localparam logic [5:0]  COUNT_RST  = 6'h00;  // settle count after reset
    localparam logic [10:0] CEIL_RST   = 11'h7FF; // ceiling after reset
    localparam logic [1:0]  OFF_CNT_RST = 2'h0;  // shutdown tick count reset

    // one loop configuration word
    typedef struct packed {
        logic [RATIO_W-1:0] prescale_ratio_a;   // input divide ratio
        logic [GAIN_W-1:0]  freq_gain_field_a;  // multiply minus one
        logic [COUNT_W-1:0] settle_cycle_count_a; // slow ticks to settle
    } plldl_cfg_s;

    // settle state
    typedef enum logic [1:0] {
        PLLDL_IDLE,    // nothing running
        PLLDL_SETTLE,  // counter decrementing
        PLLDL_LOCKED   // loop settled
    } plldl_settle_e;
endpackage
`default_nettype wire

//--- core/plldl_ctrl.sv
// prescale divider, loop enable, settle counter and gain clamp
//
// Notes on behaviour
// RQ1: divider divides source by 1 to 255
// RQ2: zero ratio holds divider and loop low
// RQ3: reset clears ratio, loop input stays low
// RQ4: output factor is (gain plus one)/ratio
// RQ5: zero gain or ratio disables the loop
// RQ6: shutdown lands two slow ticks after write
// RQ7: nonzero gain and ratio re-enable the loop
// RQ8: enable or parameter change clears settled flag
// RQ9: count loads then decrements per slow tick
// RQ10: count reaching zero sets settled flag
// RQ11: software gives enough settle ticks
// RQ12: applied gain clamped to gain ceiling
// RQ13: no oscillator changes while loop drives master
// RQ14: software follows the oscillator change sequence
// RQ15: write during settling restarts the count
// RQ16: writes act on the settle logic per slow tick
`default_nettype none
module plldl_ctrl (
    // clock, reset, freeze
    input  wire logic                  CLK,
    input  wire logic                  RST_N,
    input  wire logic                  CE,
    // timing references, sampled on CLK
    input  wire logic                  SLOW_CLOCK,
    input  wire logic                  SRC_CLOCK,
    // configuration writes
    input  wire logic                  CFG_WR,
    input  wire plldl_pkg::plldl_cfg_s CFG,
    input  wire logic                  CEIL_WR,
    input  wire logic [10:0]           GAIN_CEILING,
    // status and loop view
    output var  logic                  DIV_OUT,
    output var  logic                  LOOP_CLK_OUT,
    output var  logic                  LOOP_ON,
    output var  logic                  LOOP_SETTLED,
    output var  logic [10:0]           APPLIED_GAIN,
    output var  logic [7:0]            FACTOR_DEN
);
    // configuration state
    plldl_pkg::plldl_cfg_s cfg_ff,  nxt_cfg;    // programmed word
    logic [10:0]           ceil_ff, nxt_ceil;   // gain ceiling
    logic                  pend_ff, nxt_pend;   // write awaiting a slow tick
    // slow clock sampling
    logic                  slow_s1_ff, slow_s2_ff, slow_s3_ff;
    logic                  tick;                // one cycle per slow rise
    // loop enable and settle state
    logic                  on_ff, nxt_on;
    logic [1:0]            off_cnt_ff, nxt_off_cnt;
    logic [5:0]            cnt_ff, nxt_cnt;
    plldl_pkg::plldl_settle_e st_ff, nxt_st;
    logic                  want_on;             // both fields nonzero
    // divider state
    logic                  src_q_ff;
    logic [7:0]            div_cnt_ff, nxt_div_cnt;
    logic                  nxt_div_out, nxt_loop_clk;
    logic [10:0]           nxt_gain;
    logic                  any_wr;
    logic                  nxt_settled;         // settled flag, next cycle

    // slow clock synchroniser; the second and third stages feed the edge detect
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            slow_s1_ff <= 1'b0;
            slow_s2_ff <= 1'b0;
            slow_s3_ff <= 1'b0;
        end
        else if (CE)
        begin
            slow_s1_ff <= SLOW_CLOCK;
            slow_s2_ff <= slow_s1_ff;
            slow_s3_ff <= slow_s2_ff;
        end
    end
    assign tick   = slow_s2_ff & ~slow_s3_ff;
    assign any_wr = CFG_WR | CEIL_WR;
    assign want_on = (cfg_ff.prescale_ratio_a != 8'h00) &&
                     (cfg_ff.freq_gain_field_a != 11'h000); // [RQ5] [RQ7]

    // next configuration and loop control
    always_comb
    begin
        nxt_cfg     = cfg_ff;
        nxt_ceil    = ceil_ff;
        nxt_pend    = pend_ff;
        nxt_on      = on_ff;
        nxt_off_cnt = off_cnt_ff;
        nxt_cnt     = cnt_ff;
        nxt_st      = st_ff;
        if (tick)
        begin
            // enable follows at once, disable waits out the delay
            if (want_on)
            begin
                nxt_on      = 1'b1; // [RQ7]
                nxt_off_cnt = plldl_pkg::OFF_CNT_RST;
            end
            else if (on_ff)
            begin
                nxt_off_cnt = off_cnt_ff + 2'h1;
                if (nxt_off_cnt == 2'(plldl_pkg::OFF_DELAY))
                    nxt_on = 1'b0; // [RQ6]
            end
            // pending write is picked up only on a slow tick
            if (pend_ff)
            begin
                nxt_pend = 1'b0; // [RQ16]
                if (!want_on)
                    nxt_st = plldl_pkg::PLLDL_IDLE;
                else if (cfg_ff.settle_cycle_count_a == 6'h00)
                    nxt_st = plldl_pkg::PLLDL_LOCKED; // [RQ10]
                else
                begin
                    nxt_cnt = cfg_ff.settle_cycle_count_a; // [RQ9] [RQ15]
                    nxt_st  = plldl_pkg::PLLDL_SETTLE;
                end
            end
            else if (st_ff == plldl_pkg::PLLDL_SETTLE)
            begin
                nxt_cnt = cnt_ff - 6'h01; // [RQ9]
                if (cnt_ff == 6'h01)
                    nxt_st = plldl_pkg::PLLDL_LOCKED; // [RQ10]
            end
        end
        // a write wins over a tick that retires the old one
        if (CFG_WR)
            nxt_cfg = CFG;
        if (CEIL_WR)
            nxt_ceil = GAIN_CEILING;
        if (any_wr)
        begin
            nxt_pend = 1'b1;
            nxt_st   = plldl_pkg::PLLDL_IDLE; // [RQ8] [RQ15]
        end
    end

    // divider and outputs; the loop output is a gated stand-in
    always_comb
    begin
        nxt_div_cnt = div_cnt_ff;
        if (SRC_CLOCK && !src_q_ff)
        begin
            if (div_cnt_ff + 8'h01 >= cfg_ff.prescale_ratio_a)
                nxt_div_cnt = 8'h00; // [RQ1]
            else
                nxt_div_cnt = div_cnt_ff + 8'h01;
        end
        if (cfg_ff.prescale_ratio_a == 8'h00)
            nxt_div_out = 1'b0; // [RQ2]
        else if (cfg_ff.prescale_ratio_a == 8'h01)
            nxt_div_out = SRC_CLOCK;
        else
            nxt_div_out = div_cnt_ff < (cfg_ff.prescale_ratio_a >> 1); // [RQ1]
        nxt_loop_clk = on_ff & DIV_OUT; // [RQ2]
        // a write in this cycle keeps the flag low at once
        nxt_settled  = (st_ff == plldl_pkg::PLLDL_LOCKED) // [RQ10]
                       && !any_wr; // [RQ8]
        // clamp so an oversized gain never reaches the loop
        if (cfg_ff.freq_gain_field_a > ceil_ff)
            nxt_gain = ceil_ff; // [RQ12]
        else
            nxt_gain = cfg_ff.freq_gain_field_a; // [RQ4]
    end

    // state registers
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            cfg_ff       <= '{plldl_pkg::RATIO_RST, plldl_pkg::GAIN_RST,
                              plldl_pkg::COUNT_RST}; // [RQ3]
            ceil_ff      <= plldl_pkg::CEIL_RST;
            pend_ff      <= 1'b0;
            on_ff        <= 1'b0;
            off_cnt_ff   <= plldl_pkg::OFF_CNT_RST;
            cnt_ff       <= plldl_pkg::COUNT_RST;
            st_ff        <= plldl_pkg::PLLDL_IDLE;
            src_q_ff     <= 1'b0;
            div_cnt_ff   <= 8'h00;
            DIV_OUT      <= 1'b0;
            LOOP_CLK_OUT <= 1'b0;
            LOOP_ON      <= 1'b0;
            LOOP_SETTLED <= 1'b0;
            APPLIED_GAIN <= 11'h000;
            FACTOR_DEN   <= 8'h00;
        end
        else if (CE)
        begin
            cfg_ff       <= nxt_cfg;
            ceil_ff      <= nxt_ceil;
            pend_ff      <= nxt_pend;
            on_ff        <= nxt_on;
            off_cnt_ff   <= nxt_off_cnt;
            cnt_ff       <= nxt_cnt;
            st_ff        <= nxt_st;
            src_q_ff     <= SRC_CLOCK;
            div_cnt_ff   <= nxt_div_cnt;
            DIV_OUT      <= nxt_div_out;
            LOOP_CLK_OUT <= nxt_loop_clk;
            LOOP_ON      <= on_ff;
            LOOP_SETTLED <= nxt_settled;
            APPLIED_GAIN <= nxt_gain;
            FACTOR_DEN   <= cfg_ff.prescale_ratio_a;
        end
    end

    // checks on the above
    a_zero_ratio_low: assert property ( // [RQ2]
        @(posedge CLK) disable iff (!RST_N || !CE)
        $past(cfg_ff.prescale_ratio_a) == 8'h00 |-> !DIV_OUT)
        else $error("divider output high with zero ratio");
    a_loop_off_low: assert property ( // [RQ2]
        @(posedge CLK) disable iff (!RST_N || !CE)
        !$past(on_ff) |-> !LOOP_CLK_OUT)
        else $error("loop output high while loop off");
    a_reset_ratio: assert property ( // [RQ3]
        @(posedge CLK) disable iff (!RST_N)
        $past(!RST_N) |-> cfg_ff.prescale_ratio_a == 8'h00)
        else $error("ratio not cleared by reset");
    a_write_clears: assert property ( // [RQ8]
        @(posedge CLK) disable iff (!RST_N || !CE)
        any_wr |=> !LOOP_SETTLED)
        else $error("settled flag survived a write");
    a_count_expiry: assert property ( // [RQ10]
        @(posedge CLK) disable iff (!RST_N || !CE)
        tick && !pend_ff && !any_wr && st_ff == plldl_pkg::PLLDL_SETTLE
        && cnt_ff == 6'h01 |=> ##1 LOOP_SETTLED)
        else $error("settled flag late after count expiry");
    a_gain_clamp: assert property ( // [RQ12]
        @(posedge CLK) disable iff (!RST_N || !CE)
        APPLIED_GAIN <= $past(ceil_ff))
        else $error("applied gain above ceiling");
    a_off_delay: assert property ( // [RQ6]
        @(posedge CLK) disable iff (!RST_N || !CE)
        $fell(on_ff) |-> $past(tick) && $past(off_cnt_ff) == 2'h1)
        else $error("loop shut down at wrong slow tick");
    a_reenable: assert property ( // [RQ7]
        @(posedge CLK) disable iff (!RST_N || !CE)
        tick && want_on |=> on_ff)
        else $error("loop not enabled with nonzero fields");
    a_restart_load: assert property ( // [RQ9] [RQ15]
        @(posedge CLK) disable iff (!RST_N || !CE)
        tick && pend_ff && !any_wr && want_on
        && cfg_ff.settle_cycle_count_a != 6'h00
        |=> cnt_ff == $past(cfg_ff.settle_cycle_count_a))
        else $error("settle count not reloaded");
endmodule
`default_nettype wire

//--- verification/pll_divider_lock_control_bench.sv
// self-checking random bench for the divider and loop control block
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("unexpected %s: expected %0h seen %0h", \
                     nm, exp, got); \
        end \
    end
module pll_divider_lock_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk          = 1'b0;   // 200 MHz core clock
    logic                  rst_n        = 1'b0;   // sync reset, low active
    logic                  ce           = 1'b1;   // frozen once mid-run
    logic                  slow_clock   = 1'b0;   // slow tick reference
    logic [2:0]            src_cnt      = 3'h0;   // source is bit 2, 8 cycles
    logic                  cfg_wr       = 1'b0;   // config write pulse
    plldl_pkg::plldl_cfg_s cfg          = '0;     // config word
    logic                  ceil_wr      = 1'b0;   // ceiling write pulse
    logic [10:0]           gain_ceiling = 11'h000;
    logic [10:0]           ceil_v       = 11'h7FF; // ceiling the bench expects
    logic                  div_out;
    logic                  loop_clk_out;
    logic                  loop_on;
    logic                  loop_settled;
    logic [10:0]           applied_gain;
    logic [7:0]            factor_den;
    int                    failures     = 0;      // mismatches
    int                    checks       = 0;      // comparisons made
    int                    dr;                    // divider rises seen
    int                    lr;                    // loop clock rises seen

    plldl_ctrl plldl_ctrl_i (.CLK(clk), .RST_N(rst_n), .CE(ce),
        .SLOW_CLOCK(slow_clock), .SRC_CLOCK(src_cnt[2]), .CFG_WR(cfg_wr),
        .CFG(cfg), .CEIL_WR(ceil_wr), .GAIN_CEILING(gain_ceiling),
        .DIV_OUT(div_out), .LOOP_CLK_OUT(loop_clk_out), .LOOP_ON(loop_on),
        .LOOP_SETTLED(loop_settled), .APPLIED_GAIN(applied_gain),
        .FACTOR_DEN(factor_den));

    // clock and a source far below half the core rate
    always #2.5 clk = ~clk;
    // source rate is never retuned while the loop runs
    always @(negedge clk) src_cnt <= src_cnt + 3'h1;

    // expected gain after the ceiling clamp
    function automatic logic [10:0] clamp(input logic [10:0] g,
                                          input logic [10:0] c);
        return (g > c) ? c : g;
    endfunction

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // eight core cycles per tick leave room for the 3-cycle sync
    task automatic tick(input int n);
        repeat (n)
        begin
            slow_clock = 1'b1;
            cycles(4);
            slow_clock = 1'b0;
            cycles(4);
        end
    endtask

    task automatic write_cfg(input logic [7:0] r, input logic [10:0] g,
                             input logic [5:0] c);
        cfg    = '{r, g, c};
        cfg_wr = 1'b1;
        cycles(1);
        cfg_wr = 1'b0;
        cycles(1);
    endtask

    task automatic set_ceil(input logic [10:0] c);
        gain_ceiling = c;
        ceil_v       = c;
        ceil_wr      = 1'b1;
        cycles(1);
        ceil_wr      = 1'b0;
    endtask

    // counts rising edges of both clocks over n cycles
    task automatic watch(input int n, output int d, output int l);
        logic pd;
        logic pl;
        d  = 0;
        l  = 0;
        pd = div_out;
        pl = loop_clk_out;
        repeat (n)
        begin
            cycles(1);
            if (div_out && !pd) d++;
            if (loop_clk_out && !pl) l++;
            pd = div_out;
            pl = loop_clk_out;
        end
    endtask

    // enable, settle and run checks for one configuration
    task automatic run(input logic [7:0] r, input logic [10:0] g,
                       input logic [5:0] c);
        write_cfg(r, g, c);
        `CHK("settled after write", 1'b0, loop_settled)
        tick(int'(c));
        `CHK("settled early", 1'b0, loop_settled)
        tick(1);
        `CHK("settled", 1'b1, loop_settled)
        `CHK("loop on", 1'b1, loop_on)
        `CHK("applied gain", clamp(g, ceil_v), applied_gain)
        `CHK("factor den", r, factor_den)
        watch(24 * int'(r), dr, lr);
        `CHK("divider period", 1'b1, (dr >= 2 && dr <= 4))
        `CHK("loop clock runs", 1'b1, (lr >= 2 && lr <= 4))
    endtask

    // zero ratio or zero gain; shutdown must lag the write
    task automatic off(input logic [7:0] r);
        write_cfg(r, (r == 8'h00) ? 11'h005 : 11'h000, 6'h00);
        tick(1);
        `CHK("on before delay", 1'b1, loop_on)
        tick(1);
        `CHK("off after delay", 1'b0, loop_on)
        watch(64, dr, lr);
        `CHK("loop clock stopped", 0, lr)
        if (r == 8'h00) `CHK("divider low", 1'b0, div_out)
        `CHK("settled while off", 1'b0, loop_settled)
    endtask

    task automatic summarize();
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // reset, corner cases, then random configs cut in mid-settle
    initial
    begin
        void'($urandom(92));
        cycles(10);
        rst_n = 1'b1;
        tick(2);
        watch(64, dr, lr);
        `CHK("divider at reset", 0, dr)
        `CHK("on at reset", 1'b0, loop_on)
        `CHK("den at reset", 8'h00, factor_den)
        `CHK("settled at reset", 1'b0, loop_settled)
        run(8'h01, 11'h7FF, 6'h00);
        // loop cycled off and on, lock awaited before use
        off(8'h00);
        run(8'hFF, 11'h001, 6'h3F);
        // a write while frozen must leave everything as it was
        ce = 1'b0;
        write_cfg(8'h00, 11'h000, 6'h00);
        ce = 1'b1;
        `CHK("on while frozen", 1'b1, loop_on)
        `CHK("den while frozen", 8'hFF, factor_den)
        `CHK("settled while frozen", 1'b1, loop_settled)
        off(8'h03);
        repeat (6)
        begin
            set_ceil(11'($urandom_range(1, 2047)));
            write_cfg(8'($urandom_range(1, 40)), 11'h010, 6'h05);
            tick(3);
            run(8'($urandom_range(1, 40)), 11'($urandom_range(1, 2047)),
                6'($urandom_range(0, 63)));
        end
        summarize();
    end
endmodule
`undef CHK
`default_nettype wire
